// ===== inc/adc_fmt_pkg.sv
// constants, types and helpers shared by the converter output formatter
package adc_fmt_pkg;

  // sample widths
  localparam int CODE_W  = 8;
  localparam int RAW_W   = 9;

  // quantizer level limits (two's complement) and output codes
  localparam logic [RAW_W-1:0]  RAW_FULL_SCALE  = 9'h07F;
  localparam logic [RAW_W-1:0]  RAW_ZERO_SCALE  = 9'h180;
  localparam logic [CODE_W-1:0] CODE_FULL_SCALE = 8'hFF;
  localparam logic [CODE_W-1:0] CODE_ZERO_SCALE = 8'h00;
  localparam logic [CODE_W-1:0] CODE_SIGN_FLIP  = 8'h80;
  localparam logic [CODE_W-1:0] CODE_AUX_OFF    = 8'hFF;

  // pipeline depth between conversion and output stage; six stages put the
  // half-rate ports 7 and 8 cycles behind their samples, 7.5/8.5 at mid-strobe
  localparam int PIPE_DEPTH = 6;

  // divider phases
  localparam int               PHASE_W        = 2;
  localparam logic [PHASE_W-1:0] PHASE_CAPTURE  = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_HALF_UPD = 2'h1;
  localparam logic [PHASE_W-1:0] PHASE_QUAR_UPD = 2'h2;

  // register byte offsets
  localparam int               ADDR_W      = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATE  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'hC;

  // field positions
  localparam int CTRL_PHASE_RST = 0;
  localparam int EVT_OVERRANGE  = 0;
  localparam int EVT_MODE_CHG   = 1;
  localparam int EVT_W          = 2;
  localparam int STATE_MODE_LSB = 0;
  localparam int STATE_POWER    = 2;
  localparam int STATE_PHASE_LSB = 4;

  // reset values
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

  typedef enum logic [1:0] {
    single_rate_mode,
    half_rate_mode,
    quarter_rate_mode
  } rate_mode_e;

  typedef struct packed {
    logic              over;
    logic [CODE_W-1:0] code;
  } sample_s;

  localparam sample_s SAMPLE_RESET = '{over: 1'b0, code: 8'h00};

  // mode from the two strap-like control pins
  function automatic rate_mode_e decode_mode(input logic split_en, input logic rate_sel);
    if (!split_en) begin
      return single_rate_mode;
    end
    return rate_sel ? quarter_rate_mode : half_rate_mode;
  endfunction

endpackage

// ===== src/adc_output_demux_formatter.sv
// output demux and formatter of the 8-bit converter with register slave
// What this block does
// - every output sample is an unsigned offset-binary code
// - split-output enable high turns the 1:2 demux on, low turns it off
// - with demux on, rate select low gives half rate, high quarter rate
// - single rate: sample on primary port, same on auxiliary one cycle later
// - both auxiliary power inputs low: auxiliary true and complement held high
// - half rate: each port delivers words at half the sample rate
// - half rate: both ports update together, older sample on auxiliary
// - quarter rate: every second sample dropped, each port at quarter rate
// - half and quarter rate: overrange flag if either port sample overranged
// - single rate: overrange flag follows the primary port sample only
// - zero input gives a midscale code toggling 01111111 and 10000000
// - code 11111111 at full scale, 00000000 at zero scale, saturating beyond
// - half rate: auxiliary data lags 8.5 cycles, primary 7.5 cycles
// - divider phase starts at capture after reset; a phase reset forces it back to capture
`timescale 1ns/10ps
`default_nettype none
module adc_output_demux_formatter
  import adc_fmt_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // quantizer level, two's complement, one per clock
  input  wire logic [RAW_W-1:0]  raw_level,
  // control pins
  input  wire logic              split_output_enable,
  input  wire logic              rate_select,
  input  wire logic              second_port_power_a,
  input  wire logic              second_port_power_b,
  // output ports
  output logic [CODE_W-1:0]      primary_data,
  output logic [CODE_W-1:0]      aux_data,
  output logic [CODE_W-1:0]      aux_data_n,
  output logic                   overrange,
  output logic                   output_strobe_clock,
  output logic                   irq,
  // classic wishbone slave
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;

  // two flops; only the second is read by logic
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= {second_port_power_b, second_port_power_a, rate_select,
                     split_output_enable};
      pin_sync_q <= pin_meta_q;
    end
  end

  rate_mode_e mode;
  logic       aux_powered;

  assign mode        = decode_mode(pin_sync_q[0], pin_sync_q[1]);
  // either power input high keeps the drivers alive
  assign aux_powered = pin_sync_q[2] | pin_sync_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // conversion stage

  sample_s conv_d;
  sample_s conv_q;

  // clamp to the code range and flip the sign bit
  always_comb begin
    conv_d = SAMPLE_RESET;
    if ($signed(raw_level) >= $signed(RAW_FULL_SCALE)) begin
      conv_d.code = CODE_FULL_SCALE;
      conv_d.over = 1'b1;
    end else if ($signed(raw_level) <= $signed(RAW_ZERO_SCALE)) begin
      conv_d.code = CODE_ZERO_SCALE;
    end else begin
      // levels -1 and 0 land on 7F and 80 around zero input
      conv_d.code = raw_level[CODE_W-1:0] ^ CODE_SIGN_FLIP;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conv_q <= SAMPLE_RESET;
    end else begin
      conv_q <= conv_d;
    end
  end

  // delay sized so the half-rate port latency comes out right
  sample_s piped;

  sample_delay_line #(
    .DEPTH (PIPE_DEPTH)
  ) u_delay (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .data_in  (conv_q),
    .data_out (piped)
  );

  ////////////////////////////////////////////////////////////////////////////
  // divider phase and demux

  logic [PHASE_W-1:0] phase_d;
  logic [PHASE_W-1:0] phase_q;
  sample_s            hold_d;
  sample_s            hold_q;
  sample_s            prim_d;
  sample_s            prim_q;
  sample_s            aux_d;
  sample_s            aux_q;
  logic               over_d;
  logic               over_q;
  logic               strobe_d;
  logic               strobe_q;
  logic [CODE_W-1:0]  aux_pin_d;
  logic [CODE_W-1:0]  aux_pin_q;
  logic [CODE_W-1:0]  aux_pin_n_d;
  logic [CODE_W-1:0]  aux_pin_n_q;
  rate_mode_e         mode_q;
  logic               update;
  logic               phase_rst;

  always_comb begin
    phase_d  = phase_q;
    hold_d   = hold_q;
    prim_d   = prim_q;
    aux_d    = aux_q;
    over_d   = over_q;
    strobe_d = strobe_q;
    update   = 1'b0;
    unique case (mode)
      single_rate_mode: begin
        phase_d  = PHASE_CAPTURE;
        update   = 1'b1;
        prim_d   = piped;
        aux_d    = prim_q;
        over_d   = piped.over;
        strobe_d = ~strobe_q; // both edges mark new data
      end
      half_rate_mode: begin
        // only phases 0 and 1; a leftover phase 2 or 3 folds back
        phase_d  = {1'b0, ~phase_q[0]};
        update   = (phase_q == PHASE_HALF_UPD);
        strobe_d = update;
        if (phase_q == PHASE_CAPTURE) begin
          hold_d = piped;
        end
        if (update) begin
          prim_d = piped;
          aux_d  = hold_q;
          over_d = piped.over | hold_q.over;
        end
      end
      quarter_rate_mode: begin
        phase_d  = phase_q + 2'h1;
        update   = (phase_q == PHASE_QUAR_UPD);
        strobe_d = phase_q[1]; // high two cycles from the update
        // phases 1 and 3 are the dropped samples
        if (phase_q == PHASE_CAPTURE) begin
          hold_d = piped;
        end
        if (update) begin
          prim_d = piped;
          aux_d  = hold_q;
          over_d = piped.over | hold_q.over;
        end
      end
      default: begin
        phase_d = PHASE_CAPTURE;
      end
    endcase
    // software phase reset wins over the free-running count
    if (phase_rst) begin
      phase_d = PHASE_CAPTURE;
    end
    // unpowered auxiliary drivers pull both legs high
    aux_pin_d   = aux_powered ? aux_d.code : CODE_AUX_OFF;
    aux_pin_n_d = aux_powered ? ~aux_d.code : CODE_AUX_OFF;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_q     <= PHASE_CAPTURE;
      hold_q      <= SAMPLE_RESET;
      prim_q      <= SAMPLE_RESET;
      aux_q       <= SAMPLE_RESET;
      over_q      <= 1'b0;
      strobe_q    <= 1'b0;
      aux_pin_q   <= CODE_AUX_OFF;
      aux_pin_n_q <= CODE_AUX_OFF;
      mode_q      <= single_rate_mode;
    end else begin
      phase_q     <= phase_d;
      hold_q      <= hold_d;
      prim_q      <= prim_d;
      aux_q       <= aux_d;
      over_q      <= over_d;
      strobe_q    <= strobe_d;
      aux_pin_q   <= aux_pin_d;
      aux_pin_n_q <= aux_pin_n_d;
      mode_q      <= mode;
    end
  end

  assign primary_data        = prim_q.code;
  assign aux_data            = aux_pin_q;
  assign aux_data_n          = aux_pin_n_q;
  assign overrange           = over_q;
  assign output_strobe_clock = strobe_q;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, status and interrupt

  logic [EVT_W-1:0] status_d;
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] mask_d;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] events;
  logic [31:0]      rdata_d;
  logic [31:0]      rdata_q;
  logic             ack_d;
  logic             ack_q;
  logic             irq_d;
  logic             irq_q;
  logic             req;
  logic             wr_lo;

  // one request per strobe; ack drops the cycle after it is given
  assign req   = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_lo = req & wb_we_i & wb_sel_i[0];
  // phase reset is a write strobe, it does not stick
  assign phase_rst = wr_lo & (wb_adr_i == ADDR_CTRL) & wb_dat_i[CTRL_PHASE_RST];

  assign events[EVT_OVERRANGE] = update & over_d;
  assign events[EVT_MODE_CHG]  = (mode != mode_q);

  always_comb begin
    status_d = status_q;
    mask_d   = mask_q;
    rdata_d  = rdata_q;
    if (wr_lo && wb_adr_i == ADDR_STATUS) begin
      status_d = status_q & ~wb_dat_i[EVT_W-1:0];
    end
    if (wr_lo && wb_adr_i == ADDR_MASK) begin
      mask_d = wb_dat_i[EVT_W-1:0];
    end
    // a new event beats a clear in the same cycle
    status_d = status_d | events;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_STATE: begin
          rdata_d = '0;
          rdata_d[STATE_MODE_LSB +: 2]        = mode;
          rdata_d[STATE_POWER]                = aux_powered;
          rdata_d[STATE_PHASE_LSB +: PHASE_W] = phase_q;
        end
        ADDR_STATUS: rdata_d = {{(32-EVT_W){1'b0}}, status_q};
        ADDR_MASK:   rdata_d = {{(32-EVT_W){1'b0}}, mask_q};
        default:     rdata_d = '0; // control and unmapped read zero
      endcase
    end
    ack_d = req;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= EVT_RESET;
      mask_q   <= EVT_RESET;
      rdata_q  <= 32'h0000_0000;
      ack_q    <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
      ack_q    <= ack_d;
      irq_q    <= irq_d;
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign irq      = irq_q;

endmodule
`default_nettype wire

// ===== src/sample_delay_line.sv
// fixed-depth delay line for converted samples, registered output
`timescale 1ns/10ps
`default_nettype none
module sample_delay_line
  import adc_fmt_pkg::*;
#(
  parameter int DEPTH = PIPE_DEPTH
) (
  input  wire logic    clk_sys,
  input  wire logic    reset_n,
  input  wire sample_s data_in,
  output var sample_s  data_out
);

  sample_s stage_q [DEPTH];
  sample_s stage_d [DEPTH];

  // shift one place per clock
  always_comb begin
    stage_d[0] = data_in;
    for (int i = 1; i < DEPTH; i++) begin
      stage_d[i] = stage_q[i-1];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_q[i] <= SAMPLE_RESET;
      end
    end else begin
      stage_q <= stage_d;
    end
  end

  assign data_out = stage_q[DEPTH-1];

endmodule
`default_nettype wire

// ===== verification/adc_fmt_asserts.sv
// concurrent checks on the formatter ports
`timescale 1ns/10ps
`default_nettype none
module adc_fmt_asserts
  import adc_fmt_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              split_output_enable,
  input wire logic              rate_select,
  input wire logic              second_port_power_a,
  input wire logic              second_port_power_b,
  input wire logic [CODE_W-1:0] primary_data,
  input wire logic [CODE_W-1:0] aux_data,
  input wire logic [CODE_W-1:0] aux_data_n,
  input wire logic              overrange,
  input wire logic              output_strobe_clock,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic pw, sn, sg, dm, hf, qt, s;
  ////////////////////////////////////////
  // pin decodes; pins pass a synchroniser, so mode checks want 8 stable cycles, the parking check 5
  assign pw = second_port_power_a | second_port_power_b;
  assign sn = !split_output_enable;
  assign sg = sn & pw;
  assign dm = split_output_enable & pw;
  assign hf = dm & !rate_select;
  assign qt = dm & rate_select;
  assign s = output_strobe_clock;
  ////////////////////////////////////////
  a_aux_parked: assert property ((!pw)[*5] |-> (aux_data & aux_data_n) == 8'hFF)
    else $error("aux port not parked high");
  a_single_lag: assert property (sg[*8] |-> aux_data == $past(primary_data))
    else $error("aux not one cycle behind primary");
  a_single_over: assert property (sn[*8] |-> overrange == (primary_data == 8'hFF))
    else $error("single rate flag not tied to primary");
  a_split_over: assert property (dm[*8] |-> overrange == (&primary_data || &aux_data))
    else $error("split flag not tied to both ports");
  // a phase reset write may legally stretch one low half-period
  a_half_rate: assert property (hf[*8] ##0 !$past(wb_ack_o) |-> s != $past(s))
    else $error("half rate strobe not alternating");
  a_half_hold: assert property (hf[*8] ##0 !$rose(s) |-> $stable(primary_data) && $stable(aux_data))
    else $error("port changed off the strobe");
  a_quarter_period: assert property (qt[*8] ##0 $rose(s) ##1 qt[*4] |->
    s && !$past(s) && !$past(s, 2) && $past(s, 3))
    else $error("quarter rate strobe period wrong");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
endmodule
bind adc_output_demux_formatter adc_fmt_asserts chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .split_output_enable(split_output_enable),
  .rate_select(rate_select), .second_port_power_a(second_port_power_a),
  .second_port_power_b(second_port_power_b), .primary_data(primary_data),
  .aux_data(aux_data), .aux_data_n(aux_data_n), .overrange(overrange),
  .output_strobe_clock(output_strobe_clock), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ===== verification/adc_fmt_capture.sv
// downstream capture model latching both output ports
`timescale 1ns/10ps
`default_nettype none
module adc_fmt_capture
  import adc_fmt_pkg::*;
(
  input  wire logic              output_strobe_clock,
  input  wire logic [CODE_W-1:0] primary_data,
  input  wire logic [CODE_W-1:0] aux_data,
  input  wire logic              overrange,
  output logic [CODE_W-1:0]      cap_primary,
  output logic [CODE_W-1:0]      cap_aux,
  output logic                   cap_over,
  output int                     cap_count
);
  ////////////////////////////////////////
  // falling strobe sits mid-word in half and quarter rate, where setup and hold margin is widest
  initial cap_count = 0;
  always @(negedge output_strobe_clock) begin
    cap_primary <= primary_data;
    cap_aux <= aux_data;
    cap_over <= overrange;
    cap_count <= cap_count + 1;
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the converter output formatter
`timescale 1ns/10ps
`default_nettype none
module tb;
  import adc_fmt_pkg::*;
  logic              clk_sys = 0, reset_n = 0, sp = 0, rs = 0, pa = 0, pb = 0;
  logic              ovr, stb, irq, co, ack, cyc = 0, we = 0;
  logic [RAW_W-1:0]  raw = '0;
  logic [CODE_W-1:0] pd, ad, adn, cp, ca;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0]       wdat = '0, rdat, r;
  logic [3:0]        sel = 4'hF;
  int                fails = 0, total_checks = 0, cn, seen, md, k, j, on = 0, cyc_n = 0;
  int                h[$];
  // edge values: midscale toggle, both saturations, overranges at odd spacing
  logic [RAW_W-1:0]  pat[$] = '{9'h000, 9'h1FF, 9'h000, 9'h1FF, 9'h07F, 9'h0C8, 9'h180,
                               9'h100, 9'h07E, 9'h181, 9'h000, 9'h07F, 9'h000, 9'h07F};
  logic [RAW_W-1:0]  dq[$];

  adc_output_demux_formatter dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .raw_level(raw),
    .split_output_enable(sp), .rate_select(rs),
    .second_port_power_a(pa), .second_port_power_b(pb),
    .primary_data(pd), .aux_data(ad), .aux_data_n(adn), .overrange(ovr),
    .output_strobe_clock(stb), .irq(irq), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  adc_fmt_capture cap_u (
    .output_strobe_clock(stb), .primary_data(pd), .aux_data(ad), .overrange(ovr),
    .cap_primary(cp), .cap_aux(ca), .cap_over(co), .cap_count(cn));

  ////////////////////////////////////////
  // 40 MHz sample clock, far inside the single rate ceiling
  always #12.5 clk_sys = ~clk_sys;

  // reference conversion; bit 8 carries the overrange flag
  function automatic int conv(logic [RAW_W-1:0] v);
    int x;
    x = $signed(v);
    if (x >= 127) return 511;
    if (x <= -128) return 0;
    return x + 128;
  endfunction

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // classic single cycle; request held until ack is sampled
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    {cyc, we, adr, wdat} <= {1'b1, w, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = rdat;
    cyc <= 0;
    @(posedge clk_sys);
  endtask

  // pins change, settle past the synchroniser, then stream and compare
  task automatic mode(logic s, logic r2, logic a, logic b, int m, int n);
    on = 0;
    {sp, rs, pa, pb} <= {s, r2, a, b};
    repeat (16) @(posedge clk_sys);
    bus(0, ADDR_STATE, 0, r);
    chk("state", r[2:0], {a | b, 2'(m)});
    seen = cn;
    md = m;
    on = 1;
    dq = pat;
    repeat (n) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////
  // model history of what the design sampled, stimulus and hang guard
  always @(posedge clk_sys) begin
    h.push_back(conv(raw));
    if (h.size() > 16) h.pop_front();
    raw <= dq.size() ? dq.pop_front() : 9'($urandom % 254) - 9'h07F;
    cyc_n++;
    if (cyc_n == 5000) begin
      fails++;
      conclude();
    end
  end

  // single rate compared every cycle, split modes at each capture
  always @(negedge clk_sys) begin
    if (on && md == 0) begin
      chk("primary", pd, h[$-7] & 255);
      chk("over", ovr, h[$-7] >> 8);
      chk("aux", ad, (pa | pb) ? h[$-8] & 255 : 255);
      chk("aux_n", adn, (pa | pb) ? ~h[$-8] & 255 : 255);
    end
    if (on && md != 0 && cn != seen) begin
      seen = cn;
      k = md == 1 ? 8 : 9;
      j = md == 1 ? 9 : 11;
      chk("cap primary", cp, h[$-k] & 255);
      chk("cap aux", ca, h[$-j] & 255);
      chk("cap over", co, (h[$-k] | h[$-j]) >> 8);
    end
  end

  initial begin
    void'($urandom(83));
    repeat (20) @(posedge clk_sys);
    chk("reset", {pd, ad, adn, ovr, irq}, {8'h00, 8'hFF, 8'hFF, 2'b00});
    reset_n <= 1;
    @(posedge clk_sys);
    bus(0, ADDR_MASK, 0, r);
    chk("mask reset", r, 0);
    bus(1, ADDR_MASK, 1, r);
    bus(1, 4'h6, 1, r);
    bus(0, 4'h6, 0, r);
    chk("unmapped", r, 0);
    mode(0, 0, 0, 0, 0, 40);
    // overranges of the pattern raise the masked-in event
    bus(0, ADDR_STATUS, 0, r);
    chk("status set", r[0], 1);
    chk("irq", irq, 1);
    bus(1, ADDR_MASK, 0, r);
    @(posedge clk_sys);
    chk("irq masked", irq, 0);
    bus(1, ADDR_STATUS, 3, r);
    bus(0, ADDR_STATUS, 0, r);
    chk("status clear", r[0], 0);
    bus(1, ADDR_MASK, 1, r);
    @(posedge clk_sys);
    chk("irq clear", irq, 0);
    mode(0, 0, 1, 0, 0, 40);
    bus(1, ADDR_CTRL, 1, r);
    mode(1, 0, 1, 1, 1, 60);
    // a phase reset in half rate puts the next strobe high one edge after return
    bus(1, ADDR_CTRL, 1, r);
    @(posedge clk_sys);
    chk("strobe phase", stb, 1);
    bus(0, ADDR_STATUS, 0, r);
    chk("mode event", r[1], 1);
    mode(1, 1, 0, 1, 2, 60);
    mode(0, 1, 1, 1, 0, 30);
    conclude();
  end
endmodule
`default_nettype wire
